// File: rtl/uif_pkg.sv
// package of the serial channel interrupt and queue control block
// assumes one byte-wide host register port and same-clock datapath signals
package uif_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [2:0] UIF_OFS_HOLDING = 3'h0;
  localparam logic [2:0] UIF_OFS_MASK = 3'h1;
  localparam logic [2:0] UIF_OFS_IDENT = 3'h2;
  localparam logic [2:0] UIF_OFS_QCTL = 3'h2;
  localparam logic [2:0] UIF_OFS_LINE_STATE = 3'h5;
  localparam logic [2:0] UIF_OFS_MODEM_STATE = 3'h6;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int UIF_MASK_RXD = 0;
  localparam int UIF_MASK_TXR = 1;
  localparam int UIF_MASK_LINE = 2;
  localparam int UIF_MASK_MODEM = 3;
  localparam int UIF_QC_EN = 0;
  localparam int UIF_QC_RXRST = 1;
  localparam int UIF_QC_TXRST = 2;
  localparam int UIF_QC_TRIG_LO = 6;
  localparam logic [3:0] UIF_MASK_RESET = 4'h0;
  localparam logic [1:0] UIF_TRIG_RESET = 2'h0;

  // ****************************************
  // identity codes
  // ****************************************
  localparam logic [3:0] UIF_CODE_LINE = 4'h6;
  localparam logic [3:0] UIF_CODE_TMO = 4'hC;
  localparam logic [3:0] UIF_CODE_RXD = 4'h4;
  localparam logic [3:0] UIF_CODE_TXR = 4'h2;
  localparam logic [3:0] UIF_CODE_MODEM = 4'h0;
  localparam logic [3:0] UIF_CODE_NONE = 4'h1;

  // ****************************************
  // timeout counts in characters and bit times
  // ****************************************
  localparam logic [5:0] UIF_TMO_CHARS = 6'h04;
  localparam logic [5:0] UIF_TMO_EXTRA_BITS = 6'h0C;

  // receive trigger levels, index {size_sel, trig_sel}
  localparam logic [15:0][6:0] UIF_TRIG_TABLE = {
    7'h70, 7'h40, 7'h20, 7'h08,
    7'h38, 7'h20, 7'h10, 7'h04,
    7'h1C, 7'h10, 7'h08, 7'h02,
    7'h0E, 7'h08, 7'h04, 7'h01};

  typedef struct packed {
    logic line;
    logic tmo;
    logic rxd;
    logic txr;
    logic modem;
  } uif_pend_t;

endpackage : uif_pkg

// File: rtl/uif_rst_sync.sv
// reset release synchroniser
// assumes an asynchronous active-low reset from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module uif_rst_sync (
  // clock and raw reset
  input wire logic clk,
  input wire logic arst_n,
  // synchronised reset
  output logic rst_n
);
  logic meta_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      meta_r <= 1'b1;
      rst_n <= meta_r;
    end
  end
endmodule : uif_rst_sync
`default_nettype wire

// File: rtl/uif_rx_timer.sv
// receive idle timer counting bit ticks up to a limit
// assumes one tick pulse per bit time on the same clock
`timescale 1ns/1ps
`default_nettype none
module uif_rx_timer #(
  parameter int W = 6
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // control
  input wire logic run,
  input wire logic restart,
  input wire logic tick,
  input wire logic [W-1:0] limit,
  // one-cycle expiry
  output logic expire
);
  logic [W-1:0] cnt_r;
  logic done_r;

  // fires once per idle stretch; restart rearms it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      done_r <= 1'b0;
      expire <= 1'b0;
    end else if (ce) begin
      expire <= 1'b0;
      if (restart || !run) begin
        cnt_r <= '0;
        done_r <= 1'b0;
      end else if (tick && !done_r) begin
        if (cnt_r == limit - W'(1)) begin
          done_r <= 1'b1;
          expire <= 1'b1;
        end
        cnt_r <= cnt_r + W'(1);
      end
    end
  end
endmodule : uif_rx_timer
`default_nettype wire

// File: rtl/uif_ctrl.sv
// interrupt mask, interrupt identity and queue control of one serial channel
// assumes datapath fill, error and tick signals on CORE_CLK, host strobes one cycle each
//
// What this block does
// - fifo receive interrupt follows fill versus trigger
// - data ready set on push, cleared empty
// - all masks clear gives polled mode
// - error flag while errored char in fifo
// - non-fifo receive interrupt while holding full
// - transmit interrupt on empty, immediate on enable
// - overrun immediate, char errors at head
// - modem interrupt on any delta bit
// - timeout after four chars twelve bits
// - line state read clears line interrupt
// - receive clears by draining, timeout by read
// - identity read reporting it or tx write clears transmit
// - modem state read clears modem interrupt
// - identity reports highest priority pending source
// - reported source held during one read
// - identity bit zero low when pending
// - identity top bits mirror fifo enable
// - enable bit zero blocks other programming
// - receive queue reset pulse, self clearing
// - transmit queue reset pulse, self clearing
// - trigger from size select and bits
// - output gated by aux out two
`timescale 1ns/1ps
`default_nettype none
module uif_ctrl
  import uif_pkg::*;
#(
  parameter int FILL_W = 8
) (
  // clock, reset, enable
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire logic CE,
  // host register port
  input wire logic [2:0] HOST_ADDR,
  input wire logic HOST_RD,
  input wire logic HOST_WR,
  input wire logic [7:0] HOST_WDATA,
  input wire logic DIV_SEL,
  output logic [7:0] HOST_RDATA,
  // receive datapath
  input wire logic [FILL_W-1:0] RX_FILL,
  input wire logic RX_PUSH,
  input wire logic RX_PUSH_ERR,
  input wire logic RX_HEAD_ERR,
  input wire logic RX_OVERRUN,
  input wire logic BIT_TICK,
  input wire logic [3:0] CHAR_BITS,
  // transmit and modem side
  input wire logic TX_EMPTY,
  input wire logic [3:0] MODEM_DELTA,
  input wire logic AUX_OUT_TWO,
  input wire logic [1:0] SIZE_SEL,
  // queue control outputs
  output logic FIFO_EN,
  output logic RX_FIFO_RST,
  output logic TX_FIFO_RST,
  output logic [6:0] RX_TRIG,
  // status and interrupt outputs
  output logic RX_DATA_READY,
  output logic RX_FIFO_ERR,
  output logic IRQ_OUT
);

  // ****************************************
  // reset and host decode
  // ****************************************
  logic rst_n;
  uif_rst_sync u_rst (
    .clk(CORE_CLK),
    .arst_n(ARST_N),
    .rst_n(rst_n)
  );

  logic rd_hold, wr_hold, rd_ident, wr_mask, wr_qctl, rd_line, rd_modem;
  assign rd_hold = HOST_RD && !DIV_SEL && HOST_ADDR == UIF_OFS_HOLDING;
  assign wr_hold = HOST_WR && !DIV_SEL && HOST_ADDR == UIF_OFS_HOLDING;
  assign wr_mask = HOST_WR && !DIV_SEL && HOST_ADDR == UIF_OFS_MASK;
  assign rd_ident = HOST_RD && HOST_ADDR == UIF_OFS_IDENT;
  assign wr_qctl = HOST_WR && HOST_ADDR == UIF_OFS_QCTL;
  assign rd_line = HOST_RD && HOST_ADDR == UIF_OFS_LINE_STATE;
  assign rd_modem = HOST_RD && HOST_ADDR == UIF_OFS_MODEM_STATE;

  // ****************************************
  // mask and queue control registers
  // ****************************************
  logic [3:0] mask_r;
  logic [1:0] trig_sel_r;

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= UIF_MASK_RESET;
    end else if (CE && wr_mask) begin
      mask_r <= HOST_WDATA[3:0];
    end
  end

  // disabling the queues keeps the old trigger, so re-enabling needs a fresh write
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      FIFO_EN <= 1'b0;
      trig_sel_r <= UIF_TRIG_RESET;
      RX_FIFO_RST <= 1'b0;
      TX_FIFO_RST <= 1'b0;
    end else if (CE) begin
      RX_FIFO_RST <= 1'b0;
      TX_FIFO_RST <= 1'b0;
      if (wr_qctl) begin
        FIFO_EN <= HOST_WDATA[UIF_QC_EN];
        if (HOST_WDATA[UIF_QC_EN]) begin
          trig_sel_r <= HOST_WDATA[UIF_QC_TRIG_LO +: 2];
          RX_FIFO_RST <= HOST_WDATA[UIF_QC_RXRST];
          TX_FIFO_RST <= HOST_WDATA[UIF_QC_TXRST];
        end
      end
    end
  end

  logic [6:0] trig_nxt;
  assign trig_nxt = UIF_TRIG_TABLE[{SIZE_SEL, trig_sel_r}];

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      RX_TRIG <= UIF_TRIG_TABLE[0];
    end else if (CE) begin
      RX_TRIG <= trig_nxt;
    end
  end

  // ****************************************
  // receive status
  // ****************************************
  logic at_trig, rx_nonempty;
  assign rx_nonempty = RX_FILL != '0;
  assign at_trig = RX_FILL >= FILL_W'(RX_TRIG);

  // polled software reads these two whatever the masks say
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      RX_DATA_READY <= 1'b0;
    end else if (CE) begin
      RX_DATA_READY <= RX_PUSH || rx_nonempty;
    end
  end

  logic [FILL_W-1:0] err_cnt_r;
  logic pop_err;
  assign pop_err = rd_hold && rx_nonempty && RX_HEAD_ERR;

  // counts errored characters still queued
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      err_cnt_r <= '0;
      RX_FIFO_ERR <= 1'b0;
    end else if (CE) begin
      if (RX_FIFO_RST) begin
        err_cnt_r <= '0;
      end else if (RX_PUSH && RX_PUSH_ERR && !pop_err) begin
        err_cnt_r <= err_cnt_r + FILL_W'(1);
      end else if (pop_err && !(RX_PUSH && RX_PUSH_ERR) && err_cnt_r != '0) begin
        err_cnt_r <= err_cnt_r - FILL_W'(1);
      end
      RX_FIFO_ERR <= FIFO_EN && (err_cnt_r != '0 || (RX_PUSH && RX_PUSH_ERR));
    end
  end

  // ****************************************
  // receive timeout
  // ****************************************
  logic [5:0] tmo_limit;
  logic tmo_expire;
  assign tmo_limit = 6'(UIF_TMO_CHARS * 6'(CHAR_BITS)) + UIF_TMO_EXTRA_BITS;

  uif_rx_timer #(
    .W(6)
  ) u_tmo (
    .clk(CORE_CLK),
    .rst_n(rst_n),
    .ce(CE),
    .run(FIFO_EN && rx_nonempty && !at_trig),
    .restart(RX_PUSH || rd_hold),
    .tick(BIT_TICK),
    .limit(tmo_limit),
    .expire(tmo_expire)
  );

  // ****************************************
  // pending sources
  // ****************************************
  uif_pend_t pend;
  logic [3:0] ident_code;
  logic line_r, tmo_r, txr_r, modem_r;
  logic head_err_q, tx_empty_q, txr_en_q, pop_q;
  logic line_set, txr_set, modem_set;

  assign line_set = mask_r[UIF_MASK_LINE] && (RX_OVERRUN ||
    (RX_HEAD_ERR && (!head_err_q || pop_q)));
  assign txr_set = mask_r[UIF_MASK_TXR] && TX_EMPTY && (!tx_empty_q || !txr_en_q);
  assign modem_set = mask_r[UIF_MASK_MODEM] && (MODEM_DELTA != 4'h0);

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      head_err_q <= 1'b0;
      tx_empty_q <= 1'b0;
      txr_en_q <= 1'b0;
      pop_q <= 1'b0;
    end else if (CE) begin
      head_err_q <= RX_HEAD_ERR;
      tx_empty_q <= TX_EMPTY;
      txr_en_q <= mask_r[UIF_MASK_TXR];
      pop_q <= rd_hold;
    end
  end

  // in each flag a new event wins over a clearing access in the same cycle
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      line_r <= 1'b0;
    end else if (CE) begin
      if (line_set) line_r <= 1'b1;
      else if (rd_line || !mask_r[UIF_MASK_LINE]) line_r <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      tmo_r <= 1'b0;
    end else if (CE) begin
      if (tmo_expire && mask_r[UIF_MASK_RXD]) tmo_r <= 1'b1;
      else if (rd_hold || !FIFO_EN || !mask_r[UIF_MASK_RXD]) tmo_r <= 1'b0;
    end
  end

  // a holding write, a mask clear, or an identity read that reported this source clears it
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      txr_r <= 1'b0;
    end else if (CE) begin
      if (txr_set) txr_r <= 1'b1;
      else if (wr_hold || !mask_r[UIF_MASK_TXR] ||
               (rd_ident && ident_code == UIF_CODE_TXR)) txr_r <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      modem_r <= 1'b0;
    end else if (CE) begin
      if (modem_set) modem_r <= 1'b1;
      else if (rd_modem || !mask_r[UIF_MASK_MODEM]) modem_r <= 1'b0;
    end
  end

  // receive data source is a level: it drops as soon as reads drain below trigger, in non-fifo mode as soon as holding empties
  always_comb begin
    pend.line = line_r;
    pend.tmo = tmo_r;
    pend.rxd = mask_r[UIF_MASK_RXD] && (FIFO_EN ? at_trig : rx_nonempty);
    pend.txr = txr_r;
    pend.modem = modem_r;
  end

  // ****************************************
  // identity and read data
  // ****************************************
  logic [7:0] ident_val;
  logic any_pend;

  always_comb begin
    if (pend.line) ident_code = UIF_CODE_LINE;
    else if (pend.tmo) ident_code = UIF_CODE_TMO;
    else if (pend.rxd) ident_code = UIF_CODE_RXD;
    else if (pend.txr) ident_code = UIF_CODE_TXR;
    else if (pend.modem) ident_code = UIF_CODE_MODEM;
    else ident_code = UIF_CODE_NONE;
  end

  assign any_pend = pend != '0;
  assign ident_val = {FIFO_EN, FIFO_EN, 2'b00, ident_code};

  // one snapshot per read, so a late arrival cannot replace the reported source
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      HOST_RDATA <= 8'h00;
    end else if (CE && HOST_RD) begin
      if (rd_ident) HOST_RDATA <= ident_val;
      else if (HOST_ADDR == UIF_OFS_MASK && !DIV_SEL) HOST_RDATA <= {4'h0, mask_r};
      else HOST_RDATA <= 8'h00;
    end
  end

  // ****************************************
  // interrupt output
  // ****************************************
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      IRQ_OUT <= 1'b0;
    end else if (CE) begin
      IRQ_OUT <= any_pend && AUX_OUT_TWO;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_rxd_level;
    @(posedge CORE_CLK) disable iff (!rst_n)
    (CE && rd_ident && at_trig && mask_r[UIF_MASK_RXD] && !pend.line && !pend.tmo) |=> HOST_RDATA[3:0] == UIF_CODE_RXD;
  endproperty
  a_rxd_level: assert property (p_rxd_level) else $error("receive level not reported");

  property p_ready;
    @(posedge CORE_CLK) disable iff (!rst_n)
    (CE && RX_PUSH) |=> RX_DATA_READY;
  endproperty
  a_ready: assert property (p_ready) else $error("data ready missed a push");

  property p_tx_enable;
    @(posedge CORE_CLK) disable iff (!rst_n)
    (CE && $rose(mask_r[UIF_MASK_TXR]) && TX_EMPTY) |=> txr_r;
  endproperty
  a_tx_enable: assert property (p_tx_enable) else $error("no transmit interrupt on enable");

  property p_line_clear;
    @(posedge CORE_CLK) disable iff (!rst_n)
    (CE && rd_line && !line_set) |=> !line_r;
  endproperty
  a_line_clear: assert property (p_line_clear) else $error("line interrupt not cleared");

  property p_tx_clear;
    @(posedge CORE_CLK) disable iff (!rst_n)
    (CE && wr_hold && !txr_set) |=> !txr_r;
  endproperty
  a_tx_clear: assert property (p_tx_clear) else $error("transmit interrupt not cleared");

  property p_prio;
    @(posedge CORE_CLK) disable iff (!rst_n)
    (CE && rd_ident && pend.line) |=> (HOST_RDATA[3:0] == UIF_CODE_LINE && HOST_RDATA[0] == 1'b0);
  endproperty
  a_prio: assert property (p_prio) else $error("line status not top priority");

  property p_ident_read;
    @(posedge CORE_CLK) disable iff (!rst_n)
    (CE && rd_ident) |=> HOST_RDATA[0] == !$past(any_pend) && HOST_RDATA[7:6] == {2{$past(FIFO_EN)}};
  endproperty
  a_ident_read: assert property (p_ident_read) else $error("identity read wrong");

  property p_rx_reset;
    @(posedge CORE_CLK) disable iff (!rst_n)
    (CE && wr_qctl && HOST_WDATA[UIF_QC_EN] && HOST_WDATA[UIF_QC_RXRST])
      |=> RX_FIFO_RST ##1 (!RX_FIFO_RST || !$past(CE));
  endproperty
  a_rx_reset: assert property (p_rx_reset) else $error("receive reset pulse wrong");

  property p_no_prog;
    @(posedge CORE_CLK) disable iff (!rst_n)
    (CE && wr_qctl && !HOST_WDATA[UIF_QC_EN]) |=> !FIFO_EN && !TX_FIFO_RST && $stable(trig_sel_r);
  endproperty
  a_no_prog: assert property (p_no_prog) else $error("queue control programmed while disabled");

  property p_gate;
    @(posedge CORE_CLK) disable iff (!rst_n)
    (CE && !AUX_OUT_TWO) |=> !IRQ_OUT;
  endproperty
  a_gate: assert property (p_gate) else $error("interrupt not gated");

endmodule : uif_ctrl
`default_nettype wire

// File: tb/uif_ctrl_test.sv
// self-checking bench for the serial channel interrupt and queue control block
// assumes the bench stands in for host, receive and transmit datapaths and modem side
`timescale 1ns/1ps
`default_nettype none
module uif_ctrl_test;
  import uif_pkg::*;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic CORE_CLK = 1'b0;
  logic ARST_N = 1'b0;
  logic CE = 1'b1;
  logic [2:0] HOST_ADDR = 3'h0;
  logic HOST_RD = 1'b0;
  logic HOST_WR = 1'b0;
  logic [7:0] HOST_WDATA = 8'h00;
  logic DIV_SEL = 1'b0;
  logic [7:0] HOST_RDATA;
  logic [7:0] RX_FILL = 8'h00;
  logic RX_PUSH = 1'b0;
  logic RX_PUSH_ERR = 1'b0;
  logic RX_HEAD_ERR = 1'b0;
  logic RX_OVERRUN = 1'b0;
  logic BIT_TICK = 1'b0;
  logic [3:0] CHAR_BITS = 4'hA;
  logic TX_EMPTY = 1'b0;
  logic [3:0] MODEM_DELTA = 4'h0;
  logic AUX_OUT_TWO = 1'b0;
  logic [1:0] SIZE_SEL = 2'h0;
  logic FIFO_EN, RX_FIFO_RST, TX_FIFO_RST, RX_DATA_READY, RX_FIFO_ERR, IRQ_OUT;
  logic [6:0] RX_TRIG;
  int mismatches = 0;
  int total_checks = 0;
  // trigger levels worked out per size select and trigger bits
  localparam logic [7:0] TRIG_EXP [16] = '{8'h01, 8'h04, 8'h08, 8'h0E, 8'h02, 8'h08, 8'h10, 8'h1C,
    8'h04, 8'h10, 8'h20, 8'h38, 8'h08, 8'h20, 8'h40, 8'h70};

  uif_ctrl #(.FILL_W(8)) i_dut (.CORE_CLK, .ARST_N, .CE, .HOST_ADDR, .HOST_RD, .HOST_WR, .HOST_WDATA,
    .DIV_SEL, .HOST_RDATA, .RX_FILL, .RX_PUSH, .RX_PUSH_ERR, .RX_HEAD_ERR, .RX_OVERRUN, .BIT_TICK,
    .CHAR_BITS, .TX_EMPTY, .MODEM_DELTA, .AUX_OUT_TWO, .SIZE_SEL, .FIFO_EN, .RX_FIFO_RST,
    .TX_FIFO_RST, .RX_TRIG, .RX_DATA_READY, .RX_FIFO_ERR, .IRQ_OUT);

  initial begin
    forever #12.5 CORE_CLK = ~CORE_CLK;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(negedge CORE_CLK);
  endtask : cyc

  // strobe held one cycle, taken at the rising edge in between
  task automatic host_wr(input logic [2:0] a, input logic [7:0] d);
    HOST_ADDR = a;
    HOST_WDATA = d;
    HOST_WR = 1'b1;
    cyc(1);
    HOST_WR = 1'b0;
  endtask : host_wr

  task automatic host_rd(input logic [2:0] a, output logic [7:0] d);
    HOST_ADDR = a;
    HOST_RD = 1'b1;
    cyc(1);
    HOST_RD = 1'b0;
    cyc(1);
    d = HOST_RDATA;
  endtask : host_rd

  task automatic ident(input logic [7:0] exp);
    logic [7:0] d;
    host_rd(UIF_OFS_IDENT, d);
    check(d, exp);
  endtask : ident

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset_and_tx;
    logic [7:0] d;
    check({FIFO_EN, IRQ_OUT, RX_DATA_READY, RX_FIFO_ERR, 1'b0, RX_TRIG[2:0]}, 8'h01);
    ident(8'h01);
    host_wr(UIF_OFS_MASK, 8'hFF);
    host_rd(UIF_OFS_MASK, d);
    check(d, 8'h0F);
    host_wr(UIF_OFS_MASK, 8'h00);
    TX_EMPTY = 1'b1;
    cyc(2);
    ident(8'h01);
    // enable while already empty must raise at once
    host_wr(UIF_OFS_MASK, 8'h02);
    cyc(2);
    check({7'h00, IRQ_OUT}, 8'h00);
    AUX_OUT_TWO = 1'b1;
    cyc(2);
    check({7'h00, IRQ_OUT}, 8'h01);
    ident(8'h02);
    ident(8'h01);
    TX_EMPTY = 1'b0;
    cyc(2);
    TX_EMPTY = 1'b1;
    cyc(2);
    // look at the pin, not identity: an identity read would clear it before the write does
    check({7'h00, IRQ_OUT}, 8'h01);
    host_wr(UIF_OFS_HOLDING, 8'h5A);
    cyc(2);
    ident(8'h01);
    $display("test reset_and_tx done");
  endtask : t_reset_and_tx

  task automatic t_priority;
    logic [7:0] d;
    TX_EMPTY = 1'b0;
    host_wr(UIF_OFS_MASK, 8'h0E);
    TX_EMPTY = 1'b1;
    MODEM_DELTA = 4'h8;
    RX_OVERRUN = 1'b1;
    cyc(1);
    RX_OVERRUN = 1'b0;
    MODEM_DELTA = 4'h0;
    cyc(2);
    ident(8'h06);
    ident(8'h06);
    host_rd(UIF_OFS_LINE_STATE, d);
    ident(8'h02);
    ident(8'h00);
    host_rd(UIF_OFS_MODEM_STATE, d);
    ident(8'h01);
    TX_EMPTY = 1'b0;
    host_wr(UIF_OFS_MASK, 8'h00);
    $display("test priority done");
  endtask : t_priority

  task automatic t_queue_ctl;
    int nrx;
    int ntx;
    nrx = 0;
    ntx = 0;
    host_wr(UIF_OFS_QCTL, 8'hC6);
    cyc(2);
    check({FIFO_EN, RX_TRIG}, 8'h01);
    host_wr(UIF_OFS_QCTL, 8'h07);
    repeat (4) begin
      nrx += int'(RX_FIFO_RST);
      ntx += int'(TX_FIFO_RST);
      cyc(1);
    end
    check(8'(nrx), 8'h01);
    check(8'(ntx), 8'h01);
    ident(8'hC1);
    for (int s = 0; s < 4; s++) begin
      for (int t = 0; t < 4; t++) begin
        SIZE_SEL = 2'(s);
        host_wr(UIF_OFS_QCTL, {2'(t), 6'h01});
        cyc(2);
        check({1'b0, RX_TRIG}, TRIG_EXP[s * 4 + t]);
      end
    end
    SIZE_SEL = 2'h0;
    host_wr(UIF_OFS_QCTL, 8'h41);
    cyc(1);
    $display("test queue_ctl done");
  endtask : t_queue_ctl

  task automatic t_rx_fifo;
    host_wr(UIF_OFS_MASK, 8'h01);
    RX_FILL = 8'h03;
    RX_PUSH = 1'b1;
    cyc(1);
    RX_PUSH = 1'b0;
    cyc(1);
    check({7'h00, RX_DATA_READY}, 8'h01);
    ident(8'hC1);
    RX_FILL = 8'h04;
    cyc(2);
    check({7'h00, IRQ_OUT}, 8'h01);
    ident(8'hC4);
    ident(8'hC4);
    RX_FILL = 8'h03;
    cyc(2);
    ident(8'hC1);
    RX_FILL = 8'h00;
    cyc(2);
    check({7'h00, RX_DATA_READY}, 8'h00);
    $display("test rx_fifo done");
  endtask : t_rx_fifo

  task automatic t_timeout;
    RX_FILL = 8'h01;
    RX_PUSH = 1'b1;
    cyc(1);
    RX_PUSH = 1'b0;
    // four frames of ten bits plus twelve bits is fifty-two ticks
    repeat (51) begin
      BIT_TICK = 1'b1;
      cyc(1);
      BIT_TICK = 1'b0;
      cyc(1);
    end
    ident(8'hC1);
    BIT_TICK = 1'b1;
    cyc(1);
    BIT_TICK = 1'b0;
    cyc(1);
    ident(8'hCC);
    host_wr(UIF_OFS_HOLDING, 8'h00);
    HOST_ADDR = UIF_OFS_HOLDING;
    HOST_RD = 1'b1;
    RX_FILL = 8'h00;
    cyc(1);
    HOST_RD = 1'b0;
    cyc(2);
    ident(8'hC1);
    $display("test timeout done");
  endtask : t_timeout

  task automatic t_errors;
    logic [7:0] d;
    host_wr(UIF_OFS_MASK, 8'h04);
    RX_FILL = 8'h01;
    RX_PUSH = 1'b1;
    RX_PUSH_ERR = 1'b1;
    cyc(1);
    RX_PUSH = 1'b0;
    RX_PUSH_ERR = 1'b0;
    cyc(2);
    check({7'h00, RX_FIFO_ERR}, 8'h01);
    ident(8'hC1);
    RX_HEAD_ERR = 1'b1;
    cyc(2);
    ident(8'hC6);
    host_rd(UIF_OFS_LINE_STATE, d);
    ident(8'hC1);
    RX_HEAD_ERR = 1'b0;
    RX_FILL = 8'h00;
    host_wr(UIF_OFS_QCTL, 8'h43);
    cyc(3);
    check({7'h00, RX_FIFO_ERR}, 8'h00);
    $display("test errors done");
  endtask : t_errors

  task automatic t_polled_and_plain;
    host_wr(UIF_OFS_MASK, 8'h00);
    RX_FILL = 8'h04;
    RX_OVERRUN = 1'b1;
    cyc(1);
    RX_OVERRUN = 1'b0;
    cyc(2);
    ident(8'hC1);
    check({6'h00, IRQ_OUT, RX_DATA_READY}, 8'h01);
    host_wr(UIF_OFS_QCTL, 8'h00);
    RX_FILL = 8'h01;
    // a cycle between writes so the strobe is never lowered and raised in one step
    cyc(1);
    host_wr(UIF_OFS_MASK, 8'h01);
    cyc(2);
    ident(8'h04);
    RX_FILL = 8'h00;
    cyc(2);
    ident(8'h01);
    $display("test polled_and_plain done");
  endtask : t_polled_and_plain

  // ****************************************
  // main sequence and hang guard
  // ****************************************
  initial begin
    cyc(2);
    ARST_N = 1'b1;
    cyc(3);
    t_reset_and_tx();
    t_priority();
    t_queue_ctl();
    t_rx_fifo();
    t_timeout();
    t_errors();
    t_polled_and_plain();
    summarize();
  end

  initial begin
    #500000;
    mismatches++;
    summarize();
  end
endmodule : uif_ctrl_test
`default_nettype wire
